// [pfc_pkg.sv]
// Constants, command codes and carrier types for the parallel flash host.
// Assumes a single 100 MHz clock; the flash itself has no clock.
package pfc_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_SETUP_NS    = 20;
    localparam int T_STROBE_NS   = 120;
    localparam int T_HOLD_NS     = 20;
    localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC    = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC      = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SETUP_CNT  = 4'(SETUP_CYC);
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
    localparam logic [3:0] HOLD_CNT   = 4'(HOLD_CYC);

    // ==========================================================
    // Command sequence values
    localparam logic [19:0] ADDR_UNLOCK1 = 20'h05555;
    localparam logic [19:0] ADDR_UNLOCK2 = 20'h02aaa;
    localparam logic [15:0] DATA_UNLOCK1 = 16'h00aa;
    localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
    localparam logic [7:0]  CMD_READ_RESET    = 8'hf0;
    localparam logic [7:0]  CMD_ID_READ       = 8'h90;
    localparam logic [7:0]  CMD_PAGE_PROGRAM  = 8'ha0;
    localparam logic [7:0]  CMD_ERASE_SETUP   = 8'h80;
    localparam logic [7:0]  CMD_READ_STATUS   = 8'h70;
    localparam logic [7:0]  CMD_CLEAR_STATUS  = 8'h50;
    localparam logic [7:0]  CMD_ERASE_CONFIRM = 8'h10;
    localparam logic [2:0]  LEN_SINGLE = 3'h1;
    localparam logic [2:0]  LEN_SHORT  = 3'h3;
    localparam logic [2:0]  LEN_NORMAL = 3'h4;
    localparam logic [2:0]  LEN_ERASE  = 3'h6;
    localparam logic [19:0] ID_MAKER_OFS = 20'h00000;
    localparam logic [19:0] ID_PART_OFS  = 20'h00001;
    localparam int STATUS_READY_BIT = 7;
    localparam int ERASE_FAIL_BIT   = 5;
    localparam int PROG_FAIL_BIT    = 4;

    // ==========================================================
    // Types
    typedef enum logic [3:0]
    {
        OP_ARRAY_READ = 4'h0,
        OP_READ_RESET = 4'h1,
        OP_ID_CMD     = 4'h2,
        OP_PROGRAM    = 4'h3,
        OP_ERASE      = 4'h4,
        OP_STATUS     = 4'h5,
        OP_CLEAR      = 4'h6,
        OP_HW_ID      = 4'h7,
        OP_POLL       = 4'h8
    } pfc_op_e;

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h1,
        ST_ISSUE = 4'h2,
        ST_WAIT  = 4'h4,
        ST_RESP  = 4'h8
    } pfc_state_e;

    typedef enum logic [3:0]
    {
        PH_IDLE   = 4'h1,
        PH_SETUP  = 4'h2,
        PH_STROBE = 4'h4,
        PH_HOLD   = 4'h8
    } pfc_phase_e;

    typedef struct packed
    {
        pfc_op_e     op;
        logic        x16;
        logic        byte_sel;
        logic [19:0] addr;
        logic [15:0] data;
    } pfc_req_s;

    typedef struct packed
    {
        logic        write;
        logic        hv_id;
        logic        x16;
        logic        byte_sel;
        logic [19:0] addr;
        logic [15:0] data;
    } pfc_cyc_s;

endpackage

// [pfc_bus_cycle.sv]
// One asynchronous flash bus cycle: setup, chip-select strobe, hold.
// Assumes start is raised only while idle and cyc is valid with it.
`timescale 1ns/1ns
module pfc_bus_cycle
    import pfc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        start,
    input  wire pfc_cyc_s    cyc,
    output logic             done,
    output logic [15:0]      rdata,
    output logic [19:0]      flash_addr,
    output logic             flash_ce_b,
    output logic             flash_oe_b,
    output logic             flash_byte_hi,
    output logic             flash_vpp_en,
    output logic             flash_a9_hv_en,
    output logic [15:0]      dq_out,
    output logic [15:0]      dq_oe,
    input  wire logic [15:0] dq_in
);

    pfc_phase_e  phase_reg, phase_next;
    logic [3:0]  cnt_reg, cnt_next;
    pfc_cyc_s    cyc_reg, cyc_next;
    logic        done_next;
    logic [15:0] rdata_next;

    // ==========================================================
    // Sequencing
    wire phase_end = (cnt_reg == 4'h0);
    wire active    = (phase_next != PH_IDLE);
    wire strobe    = (phase_next == PH_STROBE);
    wire sample    = (phase_reg == PH_STROBE) && phase_end && !cyc_reg.write;
    wire [15:0] rd_masked = cyc_reg.x16 ? dq_in : {8'h00, dq_in[7:0]};

    always_comb
    begin
        phase_next = phase_reg;
        cnt_next   = (cnt_reg == 4'h0) ? 4'h0 : cnt_reg - 4'h1;
        cyc_next   = cyc_reg;
        done_next  = 1'b0;
        case (phase_reg)
            PH_IDLE:
                if (start)
                begin
                    phase_next = PH_SETUP;
                    cnt_next   = SETUP_CNT - 4'h1;
                    cyc_next   = cyc;
                end
            PH_SETUP:
                if (phase_end)
                begin
                    phase_next = PH_STROBE;
                    cnt_next   = STROBE_CNT - 4'h1;
                end
            PH_STROBE:
                if (phase_end)
                begin
                    phase_next = PH_HOLD;
                    cnt_next   = HOLD_CNT - 4'h1;
                end
            PH_HOLD:
                if (phase_end)
                begin
                    phase_next = PH_IDLE;
                    done_next  = 1'b1;
                end
            default:
                phase_next = PH_IDLE;
        endcase
    end

    // Read path: only low byte carries status or x8 data
    assign rdata_next = sample ? rd_masked : rdata;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_reg <= PH_IDLE;
            cnt_reg   <= 4'h0;
            cyc_reg   <= '0;
            done      <= 1'b0;
            rdata     <= 16'h0000;
        end
        else
        begin
            phase_reg <= phase_next;
            cnt_reg   <= cnt_next;
            cyc_reg   <= cyc_next;
            done      <= done_next;
            rdata     <= rdata_next;
        end
    end

    // ==========================================================
    // Pins, registered from the next phase
    wire        vpp_next  = active && cyc_next.write;
    wire        oe_b_next = !(strobe && !cyc_next.write);
    wire [15:0] out_next  = cyc_next.write ? cyc_next.data : {cyc_next.byte_sel, 15'h0000};
    wire [15:0] oe_next   = !active ? 16'h0000 :
                            cyc_next.write ? 16'hffff :
                            cyc_next.x16 ? 16'h0000 : 16'h8000;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flash_addr     <= 20'h00000;
            flash_ce_b     <= 1'b1;
            flash_oe_b     <= 1'b1;
            flash_byte_hi  <= 1'b1;
            flash_vpp_en   <= 1'b0;
            flash_a9_hv_en <= 1'b0;
            dq_out         <= 16'h0000;
            dq_oe          <= 16'h0000;
        end
        else
        begin
            flash_addr     <= cyc_next.addr;
            flash_ce_b     <= !strobe;
            flash_oe_b     <= oe_b_next;
            flash_byte_hi  <= cyc_next.x16;
            flash_vpp_en   <= vpp_next;
            flash_a9_hv_en <= active && cyc_next.hv_id;
            dq_out         <= out_next;
            dq_oe          <= oe_next;
        end
    end

    // ==========================================================
    // Checks
    a_write_gate_high: assert property (@(posedge mclk) disable iff (!rst_b)
        (!flash_ce_b && flash_vpp_en) |-> flash_oe_b)
        else $error("write strobe with output gate low");
    a_strobe_width: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(flash_ce_b) |-> ##11 !flash_ce_b ##1 flash_ce_b)
        else $error("chip select strobe width wrong");
    a_data_held_rise: assert property (@(posedge mclk) disable iff (!rst_b)
        ($rose(flash_ce_b) && flash_vpp_en) |-> $stable(dq_out) && dq_oe == 16'hffff)
        else $error("write data not held at strobe rise");
    a_vpp_spans_write: assert property (@(posedge mclk) disable iff (!rst_b)
        ($fell(flash_ce_b) && flash_vpp_en) |-> flash_vpp_en[*8])
        else $error("program voltage dropped inside write");

endmodule

// [pfc_flash_host.sv]
// Host controller that runs command sequences on a parallel NOR flash.
// Assumes the board turns vpp_en and a9_hv_en into the high pin voltages.
`timescale 1ns/1ns
module pfc_flash_host
    import pfc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        req_valid,
    input  wire pfc_req_s    req,
    output logic             req_ready,
    output logic             resp_valid,
    output logic [15:0]      resp_data,
    output logic [19:0]      flash_addr,
    output logic             flash_ce_b,
    output logic             flash_oe_b,
    output logic             flash_byte_hi,
    output logic             flash_vpp_en,
    output logic             flash_a9_hv_en,
    output logic [15:0]      dq_out,
    output logic [15:0]      dq_oe,
    input  wire logic [15:0] dq_in
);

    logic        rst_meta_reg;
    logic        rst_sync_reg;
    pfc_state_e  state_reg, state_next;
    pfc_req_s    req_reg, req_next;
    logic [2:0]  idx_reg, idx_next;
    logic [2:0]  cyc_count_reg;
    logic        resp_valid_next;
    logic [15:0] resp_data_next;
    logic        bus_done;
    logic [15:0] bus_rdata;
    pfc_cyc_s    cur_cyc;

    // ==========================================================
    // Reset release
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ==========================================================
    // Command tables
    function automatic logic [7:0] pfc_code(input pfc_op_e op);
        logic [7:0] c;
        c = CMD_READ_RESET;
        case (op)
            OP_ID_CMD:  c = CMD_ID_READ;
            OP_PROGRAM: c = CMD_PAGE_PROGRAM;
            OP_ERASE:   c = CMD_ERASE_SETUP;
            OP_STATUS:  c = CMD_READ_STATUS;
            OP_CLEAR:   c = CMD_CLEAR_STATUS;
            default:    c = CMD_READ_RESET;
        endcase
        return c;
    endfunction

    function automatic logic [2:0] pfc_len(input pfc_op_e op);
        logic [2:0] n;
        n = LEN_NORMAL;
        case (op)
            OP_ARRAY_READ, OP_HW_ID, OP_POLL: n = LEN_SINGLE;
            OP_CLEAR: n = LEN_SHORT;
            OP_ERASE: n = LEN_ERASE;
            default:  n = LEN_NORMAL;
        endcase
        return n;
    endfunction

    function automatic pfc_cyc_s pfc_step(input pfc_req_s r, input logic [2:0] i);
        pfc_cyc_s c;
        c.write    = 1'b1;
        c.hv_id    = 1'b0;
        c.x16      = 1'b1;
        c.byte_sel = 1'b0;
        c.addr     = ADDR_UNLOCK1;
        c.data     = DATA_UNLOCK1;
        case (i)
            3'h1, 3'h4:
            begin
                c.addr = ADDR_UNLOCK2;
                c.data = DATA_UNLOCK2;
            end
            3'h2: c.data = {8'h00, pfc_code(r.op)};
            3'h5: c.data = {8'h00, CMD_ERASE_CONFIRM};
            3'h3:
                if (r.op != OP_ERASE)
                begin
                    c.write    = (r.op == OP_PROGRAM);
                    c.x16      = c.write | r.x16;
                    c.byte_sel = r.byte_sel;
                    c.addr     = r.addr;
                    c.data     = r.data;
                end
            default: ;
        endcase
        if (pfc_len(r.op) == LEN_SINGLE)
        begin
            c.write    = 1'b0;
            c.x16      = r.x16;
            c.byte_sel = r.byte_sel;
            c.hv_id    = (r.op == OP_HW_ID);
            c.addr     = c.hv_id ? {18'h00000, 1'b0, r.addr[0]} : r.addr;
            c.data     = 16'h0000;
        end
        return c;
    endfunction

    // ==========================================================
    // Sequencer
    assign cur_cyc = pfc_step(req_reg, idx_reg);
    wire accept    = (state_reg == ST_IDLE) && req_valid && req_ready;
    wire last_cyc  = (idx_reg == pfc_len(req_reg.op) - 3'h1);
    wire not_ready = !bus_rdata[STATUS_READY_BIT];
    wire repoll    = (req_reg.op == OP_POLL) && not_ready;
    wire bus_start = (state_reg == ST_ISSUE);

    always_comb
    begin
        state_next      = state_reg;
        req_next        = req_reg;
        idx_next        = idx_reg;
        resp_valid_next = 1'b0;
        resp_data_next  = resp_data;
        case (state_reg)
            ST_IDLE:
                if (accept)
                begin
                    state_next = ST_ISSUE;
                    req_next   = req;
                    idx_next   = 3'h0;
                end
            ST_ISSUE:
                state_next = ST_WAIT;
            ST_WAIT:
                if (bus_done)
                begin
                    if (!last_cyc)
                    begin
                        idx_next   = idx_reg + 3'h1;
                        state_next = ST_ISSUE;
                    end
                    else if (repoll)
                        state_next = ST_ISSUE;
                    else
                    begin
                        state_next      = ST_RESP;
                        resp_valid_next = 1'b1;
                        resp_data_next  = bus_rdata;
                    end
                end
            ST_RESP:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            state_reg  <= ST_IDLE;
            req_reg    <= '0;
            idx_reg    <= 3'h0;
            req_ready  <= 1'b0;
            resp_valid <= 1'b0;
            resp_data  <= 16'h0000;
        end
        else
        begin
            state_reg  <= state_next;
            req_reg    <= req_next;
            idx_reg    <= idx_next;
            req_ready  <= (state_next == ST_IDLE);
            resp_valid <= resp_valid_next;
            resp_data  <= resp_data_next;
        end
    end

    // ==========================================================
    // Bus cycle engine
    pfc_bus_cycle u_cycle
    (
        .mclk           (mclk),
        .rst_b          (rst_sync_reg),
        .start          (bus_start),
        .cyc            (cur_cyc),
        .done           (bus_done),
        .rdata          (bus_rdata),
        .flash_addr     (flash_addr),
        .flash_ce_b     (flash_ce_b),
        .flash_oe_b     (flash_oe_b),
        .flash_byte_hi  (flash_byte_hi),
        .flash_vpp_en   (flash_vpp_en),
        .flash_a9_hv_en (flash_a9_hv_en),
        .dq_out         (dq_out),
        .dq_oe          (dq_oe),
        .dq_in          (dq_in)
    );

    // ==========================================================
    // Checks
    always_ff @(posedge mclk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            cyc_count_reg <= 3'h0;
        else if (accept)
            cyc_count_reg <= 3'h0;
        else if (bus_done && cyc_count_reg != 3'h7)
            cyc_count_reg <= cyc_count_reg + 3'h1;
    end

    a_unlock_first: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
        (bus_start && idx_reg == 3'h0 && pfc_len(req_reg.op) != 3'h1)
        |-> cur_cyc.addr == 20'h05555 && cur_cyc.data == 16'h00aa && cur_cyc.write)
        else $error("first unlock write wrong");
    a_erase_length: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
        (resp_valid && req_reg.op == OP_ERASE) |-> cyc_count_reg == 3'h6)
        else $error("erase sequence length wrong");
    a_clear_length: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
        (resp_valid && req_reg.op == OP_CLEAR) |-> cyc_count_reg == 3'h3)
        else $error("clear status sequence length wrong");
    a_erase_confirm: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
        (bus_start && req_reg.op == OP_ERASE && idx_reg == 3'h5)
        |-> cur_cyc.addr == 20'h05555 && cur_cyc.data == 16'h0010)
        else $error("erase confirm write wrong");
    a_id_bit_one: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
        (flash_a9_hv_en && !flash_ce_b) |-> !flash_addr[1] && flash_vpp_en == 1'b0)
        else $error("identifier read with address bit one high");
    a_poll_ready: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
        (resp_valid && req_reg.op == OP_POLL) |-> resp_data[7])
        else $error("poll finished while busy");
    a_resp_pulse: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
        resp_valid |=> !resp_valid && req_ready)
        else $error("response not a single pulse");

    c_erase_done:   cover property (@(posedge mclk) resp_valid && req_reg.op == OP_ERASE);
    c_program_done: cover property (@(posedge mclk) resp_valid && req_reg.op == OP_PROGRAM);
    c_hw_id_read:   cover property (@(posedge mclk) resp_valid && req_reg.op == OP_HW_ID);
    c_poll_retry:   cover property (@(posedge mclk) bus_done && repoll && last_cyc);

endmodule

// [pfc_flash_model.sv]
// Behavioural parallel NOR flash that answers the host controller's pins.
// Assumes vpp_en and a9_hv_en stand for the high pin voltages.
`timescale 1ns/1ns
module pfc_flash_model
    import pfc_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h0011, // Arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h0022, // Arbitrary value
    parameter int          BUSY_READS = 2
)
(
    input  wire logic [19:0] flash_addr,
    input  wire logic        flash_ce_b,
    input  wire logic        flash_oe_b,
    input  wire logic        flash_byte_hi,
    input  wire logic        flash_vpp_en,
    input  wire logic        flash_a9_hv_en,
    input  wire logic [15:0] dq_out,
    input  wire logic [15:0] dq_oe,
    output logic      [15:0] dq_in
);
    // ==========================================================
    // Command latch
    logic [15:0] mem [logic [19:0]];
    logic [1:0]  mode   = 2'h0; // 0 array, 1 id, 2 status
    logic        armed  = 1'b0;
    logic        erased = 1'b0;
    logic [7:0]  stat   = 8'h80;
    logic [19:0] wa     = '0;
    logic [15:0] word, val, drv;
    logic [15:0] lastv  = '0;
    int          seq    = 0;
    int          busy   = 0;
    wire         c1     = wa[14:0] == ADDR_UNLOCK1[14:0];
    wire         c2     = wa[14:0] == ADDR_UNLOCK2[14:0];
    wire         rd     = !flash_ce_b && !flash_oe_b;

    always @(negedge flash_ce_b)
        wa = flash_addr;
    always @(posedge flash_ce_b)
        if (flash_vpp_en && flash_oe_b)
            write_cycle(dq_out);

    task automatic write_cycle(input logic [15:0] w);
        logic [7:0] d;
        d = w[7:0];
        if (mode == 2'h1)
            mode = 2'h0;
        if (busy != 0)
            return;
        if (armed)
        begin
            mem[wa] = w;
            armed = 1'b0;
            busy = BUSY_READS;
            stat = 8'h00;
            mode = 2'h2;
            return;
        end
        case (seq)
            0, 3: seq = (c1 && d == 8'haa) ? seq + 1 : 0;
            1, 4: seq = (c2 && d == 8'h55) ? seq + 1 : 0;
            2:
            begin
                seq = (c1 && d == CMD_ERASE_SETUP) ? 3 : 0;
                if (c1 && d == CMD_READ_RESET) mode = 2'h0;
                if (c1 && d == CMD_ID_READ) mode = 2'h1;
                if (c1 && d == CMD_READ_STATUS) mode = 2'h2;
                if (c1 && d == CMD_CLEAR_STATUS) stat = 8'h80;
                armed = c1 && d == CMD_PAGE_PROGRAM;
            end
            default:
            begin
                seq = 0;
                if (c1 && d == CMD_ERASE_CONFIRM)
                begin
                    mem.delete();
                    erased = 1'b1;
                    busy = BUSY_READS;
                    stat = 8'h00;
                    mode = 2'h2;
                end
            end
        endcase
    endtask

    // ==========================================================
    // Read path
    always @(negedge flash_oe_b)
        if (!flash_ce_b && busy != 0)
        begin
            busy--;
            stat = (busy == 0) ? 8'h80 : 8'h00;
        end

    always @*
    begin
        if (flash_a9_hv_en && !flash_addr[1])
            word = flash_addr[0] ? PART_CODE : MAKER_CODE;
        else if (mode == 2'h1)
            word = flash_addr[0] ? PART_CODE : MAKER_CODE;
        else if (mode == 2'h2)
            word = {8'h00, stat};
        else if (mem.exists(flash_addr))
            word = mem[flash_addr];
        else
            word = erased ? 16'hffff : {flash_addr[7:0], ~flash_addr[7:0]};
        val = word;
        drv = rd ? 16'hffff : 16'h0000;
        if (rd && !flash_byte_hi && !flash_vpp_en)
        begin
            drv = 16'h00ff;
            if (dq_out[15])
                val[7:0] = word[15:8];
        end
        if (rd)
            lastv = val;
    end

    // Released lines show the inverse of the last value driven
    assign dq_in = (dq_oe & dq_out) | (~dq_oe & drv & val) | (~dq_oe & ~drv & ~lastv);
endmodule

// [pfc_flash_host_tb.sv]
// Self-checking bench for the flash host controller against a flash model.
// Assumes the model's codes and array fill pattern as set here.
`timescale 1ns/1ns
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin failures++; \
    $display("wrong value at %0t: got %h want %h", $time, g, w); end end
module pfc_flash_host_tb
    import pfc_pkg::*;
;
    localparam logic [15:0] MAKER = 16'h0011; // Arbitrary value
    localparam logic [15:0] PART  = 16'h0022; // Arbitrary value
    typedef struct packed {pfc_req_s req; logic chk; logic [15:0] exp;} pfc_row_s;
    logic        mclk      = 1'b0;
    logic        rst_b     = 1'b0;
    logic        req_valid = 1'b0;
    pfc_req_s    req       = '0;
    logic        req_ready, resp_valid, ce_b, oe_b, byte_hi, vpp_en, a9_hv;
    logic [15:0] resp_data, dq_out, dq_oe, dq_in, got;
    logic [19:0] addr;
    int          failures  = 0;
    int          n_compared = 0;
    pfc_row_s    rows [12] = '{
        '{'{OP_ARRAY_READ, 1'b1, 1'b0, 20'h12345, 16'h0}, 1'b1, 16'h45ba},
        '{'{OP_ARRAY_READ, 1'b0, 1'b0, 20'h00abc, 16'h0}, 1'b1, 16'h0043},
        '{'{OP_ARRAY_READ, 1'b0, 1'b1, 20'h00abc, 16'h0}, 1'b1, 16'h00bc},
        '{'{OP_HW_ID, 1'b1, 1'b0, 20'h00000, 16'h0}, 1'b1, MAKER},
        '{'{OP_HW_ID, 1'b0, 1'b0, 20'h00001, 16'h0}, 1'b1, {8'h00, PART[7:0]}},
        '{'{OP_ID_CMD, 1'b1, 1'b0, 20'h00000, 16'h0}, 1'b1, MAKER},
        '{'{OP_ID_CMD, 1'b1, 1'b0, 20'h00001, 16'h0}, 1'b1, PART},
        '{'{OP_READ_RESET, 1'b1, 1'b0, 20'h00077, 16'h0}, 1'b1, 16'h7788},
        '{'{OP_STATUS, 1'b1, 1'b0, 20'h54321, 16'h0}, 1'b1, 16'h0080},
        '{'{OP_STATUS, 1'b0, 1'b0, 20'h00000, 16'h0}, 1'b1, 16'h0080},
        '{'{OP_CLEAR, 1'b1, 1'b0, 20'h00000, 16'h0}, 1'b0, 16'h0000},
        '{'{OP_READ_RESET, 1'b1, 1'b0, 20'hfffff, 16'h0}, 1'b1, 16'hff00}};

    always #5 mclk = ~mclk;

    pfc_flash_host dut (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
        .flash_addr(addr), .flash_ce_b(ce_b), .flash_oe_b(oe_b), .flash_byte_hi(byte_hi),
        .flash_vpp_en(vpp_en), .flash_a9_hv_en(a9_hv), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in));
    pfc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .BUSY_READS(2)) model (
        .flash_addr(addr), .flash_ce_b(ce_b), .flash_oe_b(oe_b), .flash_byte_hi(byte_hi),
        .flash_vpp_en(vpp_en), .flash_a9_hv_en(a9_hv), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in));

    task automatic end_of_test();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hold the request until taken, then wait a bounded time for the answer
    task automatic run(input pfc_op_e op, input logic x16, input logic [19:0] a,
                       input logic [15:0] d, input logic bs = 1'b0);
        int i;
        req <= '{op, x16, bs, a, d};
        req_valid <= 1'b1;
        i = 0;
        do begin @(posedge mclk); i++; end while (!req_ready && i < 200);
        req_valid <= 1'b0;
        if (!req_ready)
        begin
            failures++;
            end_of_test();
        end
        i = 0;
        do begin @(posedge mclk); i++; end while (!resp_valid && i < 2000);
        got = resp_data;
        if (!resp_valid)
        begin
            failures++;
            end_of_test();
        end
    endtask

    initial
    begin
        repeat (12) @(posedge mclk);
        `CHK({req_ready, ce_b, oe_b, vpp_en, dq_oe}, 20'h60000)
        rst_b <= 1'b1;
        foreach (rows[k])
        begin
            run(rows[k].req.op, rows[k].req.x16, rows[k].req.addr, rows[k].req.data,
                rows[k].req.byte_sel);
            if (rows[k].chk)
                `CHK(got, rows[k].exp)
        end
        $display("table tests done");
        run(OP_PROGRAM, 1'b1, 20'h80010, 16'hbeef);
        run(OP_POLL, 1'b1, 20'h0, 16'h0);
        `CHK(got, 16'h0080)
        run(OP_ARRAY_READ, 1'b1, 20'h80010, 16'h0);
        `CHK(got, 16'h0080)
        run(OP_READ_RESET, 1'b1, 20'h80010, 16'h0);
        `CHK(got, 16'hbeef)
        run(OP_READ_RESET, 1'b1, 20'h00010, 16'h0);
        `CHK(got, 16'h10ef)
        $display("program test done");
        run(OP_ERASE, 1'b1, 20'h0, 16'h0);
        run(OP_POLL, 1'b1, 20'h0, 16'h0);
        `CHK(got, 16'h0080)
        run(OP_READ_RESET, 1'b1, 20'h80010, 16'h0);
        `CHK(got, 16'hffff)
        $display("erase test done");
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK({req_ready, ce_b, dq_oe}, 18'h10000)
        rst_b <= 1'b1;
        run(OP_ARRAY_READ, 1'b1, 20'h12345, 16'h0);
        `CHK(got, 16'hffff)
        $display("reset test done");
        end_of_test();
    end
endmodule
